// ===== irq_cfg_pkg.sv
// Package: register map, field positions and timing for the irq pin block
`default_nettype none
package irq_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_AUX_MST_CTRL   = 8'h24;
    localparam logic [7:0] IDX_AUX_MST_STATUS = 8'h36;
    localparam logic [7:0] IDX_PIN_CFG        = 8'h37;
    localparam logic [7:0] IDX_SRC_EN         = 8'h38;
    localparam logic [7:0] IDX_INT_STATUS     = 8'h3A;
    localparam logic [7:0] IDX_EVT_STATUS     = 8'h70;
    localparam logic [7:0] IDX_EVT_MASK       = 8'h71;

    // Pin configuration fields
    localparam int PIN_ACTIVE_LOW_BIT = 7;
    localparam int PIN_OPEN_DRAIN_BIT = 6;
    localparam int PIN_LATCH_BIT      = 5;
    localparam int PIN_ANY_RD_CLR_BIT = 4;
    localparam int FSYNC_ACT_LOW_BIT  = 3;
    localparam int FSYNC_MODE_BIT     = 2;
    localparam int BYPASS_BIT         = 1;

    // Source enable and status fields (same layout), then aux master status and control fields
    localparam int WOM_BIT  = 6;
    localparam int FIFO_BIT = 4;
    localparam int FS_BIT   = 3;
    localparam int RAW_BIT  = 0;
    localparam int PASS_THROUGH_BIT = 7;
    localparam int WAIT_ES_BIT      = 6;

    // Writable bits and reset values
    localparam logic [7:0] PIN_CFG_MASK  = 8'hFE;
    localparam logic [7:0] SRC_MASK      = 8'h59;
    localparam logic [7:0] PIN_CFG_RST   = 8'h00;
    localparam logic [7:0] SRC_EN_RST    = 8'h00;
    localparam logic [7:0] MST_CTRL_RST  = 8'h00;
    localparam logic [7:0] EVT_MASK_RST  = 8'h00;

    // Pulse timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PULSE_WIDTH_NS = 50000;
    localparam int PULSE_CYCLES   = PULSE_WIDTH_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W    = $clog2(PULSE_CYCLES);

    typedef enum logic {PIN_IDLE, PIN_PULSE} pin_state_t;

    typedef struct packed {
        pin_state_t               state;
        logic [PULSE_CNT_W-1:0]   cnt;
    } pin_regs_t;

    typedef struct packed {
        logic [7:0]  pin_cfg;
        logic [7:0]  src_en;
        logic [7:0]  mst_ctrl;
        logic [7:0]  int_status;
        logic        pass_thr;
        logic [7:0]  evt_status;
        logic [7:0]  evt_mask;
        logic        fs_prev;
        logic        raw_pend;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  snap_int;
        logic        snap_pt;
    } ctl_regs_t;
endpackage
`default_nettype wire

// ===== irq_host_model.sv
// Host side model: resolves the interrupt line seen by the host processor
`default_nettype none
module irq_host_model (
    input  wire logic pin_i,
    input  wire logic pin_oe_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board pull-up wins whenever the device lets go of the line
    assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule // irq_host_model
`default_nettype wire

// ===== irq_pin_ctrl.sv
// Interrupt pin and source enable controller with APB registers
`default_nettype none
// What this block does
// - Pin config bit 7 set makes the interrupt pin active low, else high.
// - Pin config bit 6 set makes the pin open drain, else push-pull.
// - Latch bit 5 set holds the pin active until status is cleared.
// - Latch bit clear gives a 50 us active pulse per interrupt.
// - Bit 4 set clears interrupt status on any register read.
// - Bit 4 clear clears status only by reading the status register.
// - Bit 3 set makes frame sync active low, else active high.
// - Bit 2 set lets a frame sync edge to active level interrupt.
// - Frame sync event shows in the aux master pass-through bit.
// - Bypass bit with aux master disabled puts aux pins in bypass.
// - No bypass and master disabled leaves aux pins undriven.
// - Enable bit 6 lets wake on motion reach the pin.
// - Enable bit 4 lets FIFO overflow reach the pin.
// - Enable bit 3 lets frame sync reach the pin.
// - Enable bit 0 lets raw data ready reach the pin.
// - Wait-for-external-sensor bit with aux master enabled delays raw data ready interrupt.
// - Status bits: motion 6, overflow 4, frame sync 3, raw ready 0.
// - Reading aux master status clears all its bits.
module irq_pin_ctrl #(
    parameter int ADDR_W = 12
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              motion_wake_evt_i,
    input  wire logic              fifo_overflow_evt_i,
    input  wire logic              raw_data_ready_evt_i,
    input  wire logic              ext_sensor_done_i,
    input  wire logic              frame_sync_i,
    input  wire logic              aux_master_enable_i,
    input  wire logic              master_clock_oe_i,
    input  wire logic              master_data_oe_i,
    input  wire logic              host_clock_i,
    input  wire logic              host_data_i,
    output logic                   int_pin_o,
    output logic                   int_pin_oe_o,
    output logic                   aux_bus_clock_pin_o,
    output logic                   aux_bus_clock_pin_oe_o,
    output logic                   aux_bus_data_pin_o,
    output logic                   aux_bus_data_pin_oe_o,
    output logic                   aux_bypass_o,
    output logic                   irq_o
);
    irq_cfg_pkg::ctl_regs_t r;
    irq_cfg_pkg::ctl_regs_t s;
    irq_pin_if pin_bus ();

    logic       setup;
    logic       access;
    logic       aligned;
    logic       mapped;
    logic [7:0] idx;
    logic [7:0] rd_mux;
    logic [7:0] set_vec;
    logic       fs_lvl;
    logic       fs_evt;
    logic       raw_go;
    logic       wait_es;
    logic       any_rd_clr;

    ////////////////////////////////////////////////////////////////////
    // APB decode; address must be word aligned with no upper bits
    assign setup   = psel_i && !penable_i;
    assign access  = psel_i && penable_i;
    assign idx     = paddr_i[9:2];
    assign aligned = (paddr_i[1:0] == 2'h0) && (paddr_i[ADDR_W-1:10] == '0);
    assign mapped  = aligned && (idx == irq_cfg_pkg::IDX_AUX_MST_CTRL
                              || idx == irq_cfg_pkg::IDX_AUX_MST_STATUS
                              || idx == irq_cfg_pkg::IDX_PIN_CFG
                              || idx == irq_cfg_pkg::IDX_SRC_EN
                              || idx == irq_cfg_pkg::IDX_INT_STATUS
                              || idx == irq_cfg_pkg::IDX_EVT_STATUS
                              || idx == irq_cfg_pkg::IDX_EVT_MASK);
    assign any_rd_clr = r.pin_cfg[irq_cfg_pkg::PIN_ANY_RD_CLR_BIT];

    // Read data mux; unused bits read as zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (idx)
            irq_cfg_pkg::IDX_AUX_MST_CTRL:   rd_mux = r.mst_ctrl;
            irq_cfg_pkg::IDX_AUX_MST_STATUS: rd_mux = {r.pass_thr, 7'h00};
            irq_cfg_pkg::IDX_PIN_CFG:        rd_mux = r.pin_cfg;
            irq_cfg_pkg::IDX_SRC_EN:         rd_mux = r.src_en;
            irq_cfg_pkg::IDX_INT_STATUS:     rd_mux = r.int_status;
            irq_cfg_pkg::IDX_EVT_STATUS:     rd_mux = r.evt_status;
            irq_cfg_pkg::IDX_EVT_MASK:       rd_mux = r.evt_mask;
            default:                         rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Event sources
    // frame sync level normalised to active high
    assign fs_lvl = frame_sync_i ^ r.pin_cfg[irq_cfg_pkg::FSYNC_ACT_LOW_BIT];
    // edge into the active level, only when the mode is on
    assign fs_evt = fs_lvl && !r.fs_prev
                 && r.pin_cfg[irq_cfg_pkg::FSYNC_MODE_BIT];
    // hold raw ready back until external sensor data has landed
    assign wait_es = r.mst_ctrl[irq_cfg_pkg::WAIT_ES_BIT]
                  && aux_master_enable_i;
    assign raw_go  = wait_es ? (ext_sensor_done_i
                                && (r.raw_pend || raw_data_ready_evt_i))
                             : raw_data_ready_evt_i;

    always_comb
    begin
        set_vec = 8'h00;
        set_vec[irq_cfg_pkg::WOM_BIT]  = motion_wake_evt_i;
        set_vec[irq_cfg_pkg::FIFO_BIT] = fifo_overflow_evt_i;
        set_vec[irq_cfg_pkg::FS_BIT]   = fs_evt;
        set_vec[irq_cfg_pkg::RAW_BIT]  = raw_go;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state. Read-clears only drop bits that were visible at the
    // setup cycle, so an event landing mid-transfer is never lost.
    always_comb
    begin
        s = r;
        s.fs_prev  = fs_lvl;
        s.raw_pend = wait_es && (r.raw_pend || raw_data_ready_evt_i)
                  && !ext_sensor_done_i;
        if (setup)
        begin
            s.prdata   = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            s.pslverr  = !mapped;
            s.snap_int = 8'h00;
            s.snap_pt  = 1'b0;
            // any read clears; else only the status register
            if (!pwrite_i && mapped && (any_rd_clr
                || idx == irq_cfg_pkg::IDX_INT_STATUS))
                s.snap_int = r.int_status;
            // aux master status read clears its flags
            if (!pwrite_i && mapped
                && idx == irq_cfg_pkg::IDX_AUX_MST_STATUS)
                s.snap_pt = r.pass_thr;
        end
        if (access && !pwrite_i)
        begin
            s.int_status = r.int_status & ~r.snap_int;
            s.pass_thr   = r.pass_thr & ~r.snap_pt;
        end
        if (access && pwrite_i && mapped && pstrb_i[0])
        begin
            case (idx)
                irq_cfg_pkg::IDX_AUX_MST_CTRL: s.mst_ctrl = pwdata_i[7:0];
                irq_cfg_pkg::IDX_PIN_CFG:
                    s.pin_cfg = pwdata_i[7:0] & irq_cfg_pkg::PIN_CFG_MASK;
                irq_cfg_pkg::IDX_SRC_EN:
                    s.src_en = pwdata_i[7:0] & irq_cfg_pkg::SRC_MASK;
                irq_cfg_pkg::IDX_EVT_STATUS:
                    s.evt_status = r.evt_status & ~pwdata_i[7:0];
                irq_cfg_pkg::IDX_EVT_MASK:
                    s.evt_mask = pwdata_i[7:0] & irq_cfg_pkg::SRC_MASK;
                default: s.mst_ctrl = r.mst_ctrl;
            endcase
        end
        // Sets are applied last so they win over any clear
        s.int_status = s.int_status | set_vec;
        s.evt_status = s.evt_status | set_vec;
        // frame sync also lands in the pass-through flag
        s.pass_thr = s.pass_thr | fs_evt;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r          <= '0;
            r.pin_cfg  <= irq_cfg_pkg::PIN_CFG_RST;
            r.src_en   <= irq_cfg_pkg::SRC_EN_RST;
            r.mst_ctrl <= irq_cfg_pkg::MST_CTRL_RST;
            r.evt_mask <= irq_cfg_pkg::EVT_MASK_RST;
        end
        else
            r <= s;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus answers: zero wait states, data from flip-flops
    assign pready_o  = 1'b1;
    assign prdata_o  = r.prdata;
    assign pslverr_o = access && r.pslverr;

    // System interrupt: sticky events gated by the mask
    assign irq_o = |(r.evt_status & r.evt_mask);

    ////////////////////////////////////////////////////////////////////
    // Pin driver hookup
    // any enabled pending flag, OR-combined
    assign pin_bus.assert_lvl = |(r.int_status & r.src_en);
    assign pin_bus.new_evt    = |(set_vec & r.src_en);
    assign pin_bus.latch_en   = r.pin_cfg[irq_cfg_pkg::PIN_LATCH_BIT];
    assign pin_bus.active_low = r.pin_cfg[irq_cfg_pkg::PIN_ACTIVE_LOW_BIT];
    assign pin_bus.open_drain = r.pin_cfg[irq_cfg_pkg::PIN_OPEN_DRAIN_BIT];
    assign int_pin_o    = pin_bus.pin_o;
    assign int_pin_oe_o = pin_bus.pin_oe;

    irq_pin_driver u_pin_driver (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pin       (pin_bus.drv)
    );

    ////////////////////////////////////////////////////////////////////
    // Aux bus pins: open drain, value always low
    // bypass follows the host bus while the master is off
    // the master drives them when enabled; with neither master nor bypass, released so the pull-up holds them high
    assign aux_bypass_o = r.pin_cfg[irq_cfg_pkg::BYPASS_BIT]
                       && !aux_master_enable_i;
    assign aux_bus_clock_pin_o = 1'b0;
    assign aux_bus_data_pin_o  = 1'b0;
    assign aux_bus_clock_pin_oe_o = aux_master_enable_i ? master_clock_oe_i
                                  : (aux_bypass_o && !host_clock_i);
    assign aux_bus_data_pin_oe_o  = aux_master_enable_i ? master_data_oe_i
                                  : (aux_bypass_o && !host_data_i);

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rd_setup(logic cond);
        setup && !pwrite_i && mapped && cond && set_vec == 8'h00;
    endsequence
    sequence s_rd_access;
        access && set_vec == 8'h00;
    endsequence

    AST_ANY_READ_CLR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_rd_setup(any_rd_clr) ##1 s_rd_access
        |=> r.int_status == 8'h00)
        else $error("any read did not clear status");
    AST_OTHER_READ_KEEPS: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        s_rd_setup(!any_rd_clr && idx != irq_cfg_pkg::IDX_INT_STATUS)
        ##1 s_rd_access |=> r.int_status == $past(r.int_status))
        else $error("status cleared by other read");
    AST_AUX_READ_CLR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        s_rd_setup(idx == irq_cfg_pkg::IDX_AUX_MST_STATUS)
        ##1 s_rd_access |=> !r.pass_thr)
        else $error("pass-through not cleared by read");
    AST_FS_EDGE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (r.pin_cfg[irq_cfg_pkg::FSYNC_MODE_BIT] && !r.fs_prev
         && (frame_sync_i != r.pin_cfg[irq_cfg_pkg::FSYNC_ACT_LOW_BIT]))
        |=> r.int_status[irq_cfg_pkg::FS_BIT] && r.pass_thr)
        else $error("frame sync edge missed");
    AST_FS_OFF: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        !r.pin_cfg[irq_cfg_pkg::FSYNC_MODE_BIT] |-> !fs_evt)
        else $error("frame sync interrupt while disabled");
    AST_STATUS_POS: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (motion_wake_evt_i || fifo_overflow_evt_i)
        |=> (r.int_status[6] || !$past(motion_wake_evt_i))
        && (r.int_status[4] || !$past(fifo_overflow_evt_i)))
        else $error("status bit position wrong");
    AST_RAW_WAIT: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (wait_es && !ext_sensor_done_i
        && !r.int_status[irq_cfg_pkg::RAW_BIT])
        |=> !r.int_status[irq_cfg_pkg::RAW_BIT])
        else $error("raw ready not held for external sensor");
    AST_SRC_GATE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (r.src_en == 8'h00) |-> !pin_bus.new_evt
        && !pin_bus.assert_lvl)
        else $error("disabled source reached the pin");
    AST_BYPASS: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) !aux_master_enable_i |->
        (aux_bypass_o == r.pin_cfg[irq_cfg_pkg::BYPASS_BIT])
        && (aux_bypass_o || (!aux_bus_clock_pin_oe_o
        && !aux_bus_data_pin_oe_o)))
        else $error("aux pin bypass wrong");

    AST_BYPASS_MIRROR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) aux_bypass_o
        |-> aux_bus_clock_pin_oe_o == !host_clock_i
        && aux_bus_data_pin_oe_o == !host_data_i)
        else $error("bypass does not mirror host");

    // Bad addresses answer with an error in the access phase
    AST_UNMAPPED_ERR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (setup && !mapped) ##1 access
        |-> pslverr_o)
        else $error("no error on unmapped address");

    // Reserved bits never hold a one, whatever software wrote
    AST_RSVD_ZERO: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        !r.pin_cfg[0] && (r.src_en & 8'hA6) == 8'h00)
        else $error("reserved bit set");

    // Read data is captured at setup and stands through access
    AST_RD_DATA: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (setup && !pwrite_i && mapped
        && idx == irq_cfg_pkg::IDX_PIN_CFG)
        |=> prdata_o == {24'h00_0000, $past(r.pin_cfg)})
        else $error("config read data wrong");

    // A write that lands at the access edge
    sequence s_wr_to(logic [7:0] a);
        access && pwrite_i && mapped && pstrb_i[0] && idx == a;
    endsequence

    AST_SRC_WR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_wr_to(irq_cfg_pkg::IDX_SRC_EN)
        |=> r.src_en == ($past(pwdata_i[7:0]) & 8'h59))
        else $error("source enable write wrong");

    AST_PIN_WR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_wr_to(irq_cfg_pkg::IDX_PIN_CFG)
        |=> r.pin_cfg == ($past(pwdata_i[7:0]) & 8'hFE))
        else $error("pin config write wrong");

    // Event status is sticky and write-one-to-clear
    AST_EVT_STICKY: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) motion_wake_evt_i
        |=> r.evt_status[6])
        else $error("event status not set");

    AST_EVT_W1C: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        s_wr_to(irq_cfg_pkg::IDX_EVT_STATUS) ##0 set_vec == 8'h00
        |=> (r.evt_status & $past(pwdata_i[7:0])) == 8'h00)
        else $error("event status not cleared");

    AST_RAW_RELEASE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (wait_es && ext_sensor_done_i && r.raw_pend)
        |=> r.int_status[irq_cfg_pkg::RAW_BIT])
        else $error("held raw ready not released");
endmodule // irq_pin_ctrl
`default_nettype wire

// ===== irq_pin_driver.sv
// Interrupt pin driver: latch or pulse, polarity and drive style
`default_nettype none
module irq_pin_driver (
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    irq_pin_if.drv     pin
);
    irq_cfg_pkg::pin_regs_t r;
    irq_cfg_pkg::pin_regs_t s;
    logic active;
    logic level;

    ////////////////////////////////////////////////////////////////////
    // Pulse timer; a new event restarts the pulse
    always_comb
    begin
        s = r;
        case (r.state)
            irq_cfg_pkg::PIN_IDLE:
            begin
                if (pin.new_evt && !pin.latch_en)
                begin
                    s.state = irq_cfg_pkg::PIN_PULSE;
                    s.cnt   = irq_cfg_pkg::PULSE_CNT_W'(
                                  irq_cfg_pkg::PULSE_CYCLES - 1);
                end
            end
            irq_cfg_pkg::PIN_PULSE:
            begin
                if (pin.new_evt && !pin.latch_en)
                    s.cnt = irq_cfg_pkg::PULSE_CNT_W'(
                                irq_cfg_pkg::PULSE_CYCLES - 1);
                else if (r.cnt == '0)
                    s.state = irq_cfg_pkg::PIN_IDLE;
                else
                    s.cnt = r.cnt - 1'b1;
            end
            default: s.state = irq_cfg_pkg::PIN_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r <= '{state: irq_cfg_pkg::PIN_IDLE, cnt: '0};
        else
            r <= s;
    end

    ////////////////////////////////////////////////////////////////////
    // latched level follows pending status
    assign active = pin.latch_en ? pin.assert_lvl
                                 : (r.state == irq_cfg_pkg::PIN_PULSE);
    assign level = active ^ pin.active_low;
    // open drain only pulls low, never drives high
    assign pin.pin_o  = pin.open_drain ? 1'b0 : level;
    assign pin.pin_oe = pin.open_drain ? !level : 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_pulse_start;
        pin.new_evt && !pin.latch_en;
    endsequence

    AST_PULSE_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_pulse_start |=> active [*8])
        else $error("pulse shorter than expected");
    AST_PULSE_END: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $fell(r.state == irq_cfg_pkg::PIN_PULSE) |-> $past(r.cnt) == '0)
        else $error("pulse ended early");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (pin.latch_en && pin.assert_lvl) |->
        ((pin.open_drain ? !pin.pin_oe : pin.pin_o) != pin.active_low))
        else $error("latched pin not active");
    AST_POLARITY: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) (!pin.open_drain && !active) |->
        pin.pin_o == pin.active_low)
        else $error("idle level wrong");
    AST_OPEN_DRAIN: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) pin.open_drain |->
        (!pin.pin_o && (pin.pin_oe == (active == pin.active_low))))
        else $error("open drain misdriven");
endmodule // irq_pin_driver
`default_nettype wire

// ===== irq_pin_if.sv
// Interface: controller to interrupt pin driver
`default_nettype none
interface irq_pin_if;
    logic assert_lvl;
    logic new_evt;
    logic latch_en;
    logic active_low;
    logic open_drain;
    logic pin_o;
    logic pin_oe;
    modport ctrl (output assert_lvl, new_evt, latch_en, active_low,
                  open_drain, input pin_o, pin_oe);
    modport drv  (input assert_lvl, new_evt, latch_en, active_low,
                  open_drain, output pin_o, pin_oe);
endinterface
`default_nettype wire

// ===== tb_interrupt_pin_and_enable_control.sv
// Testbench for the interrupt pin and source enable controller
`default_nettype none
module tb_interrupt_pin_and_enable_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_PIN = 12'(irq_cfg_pkg::IDX_PIN_CFG) << 2;
    localparam logic [11:0] A_SRC = 12'(irq_cfg_pkg::IDX_SRC_EN) << 2;
    localparam logic [11:0] A_ST  = 12'(irq_cfg_pkg::IDX_INT_STATUS) << 2;
    localparam logic [11:0] A_AUX = 12'(irq_cfg_pkg::IDX_AUX_MST_STATUS) << 2;
    localparam logic [11:0] A_MST = 12'(irq_cfg_pkg::IDX_AUX_MST_CTRL) << 2;
    localparam logic [11:0] A_EVS = 12'(irq_cfg_pkg::IDX_EVT_STATUS) << 2;
    localparam logic [11:0] A_MSK = 12'(irq_cfg_pkg::IDX_EVT_MASK) << 2;
    logic        ref_clk_i = 0, rst_n_i = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, pin, pin_oe, line, byp, irq, ck_oe, da_oe;
    logic [2:0]  evt = 0;
    logic        done = 0, fs = 1, ms_en = 0, hck = 1;
    logic [31:0] q[$];
    int          error_cnt = 0, checked = 0;
    logic [7:0]  stat_bit[3] = '{8'h40, 8'h10, 8'h01};

    always #25 ref_clk_i = ~ref_clk_i;

    irq_pin_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .motion_wake_evt_i(evt[0]), .fifo_overflow_evt_i(evt[1]),
        .raw_data_ready_evt_i(evt[2]), .ext_sensor_done_i(done),
        .frame_sync_i(fs), .aux_master_enable_i(ms_en),
        .master_clock_oe_i(1'b0), .master_data_oe_i(1'b0),
        .host_clock_i(hck), .host_data_i(hck),
        .int_pin_o(pin), .int_pin_oe_o(pin_oe),
        .aux_bus_clock_pin_o(), .aux_bus_clock_pin_oe_o(ck_oe),
        .aux_bus_data_pin_o(), .aux_bus_data_pin_oe_o(da_oe),
        .aux_bypass_o(byp), .irq_o(irq));
    irq_host_model host (.pin_i(pin), .pin_oe_i(pin_oe), .line_o(line));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("Error %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Master holds the request until pready is seen at a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(0, a, 0);
    endtask

    task automatic ev(input int k);
        @(posedge ref_clk_i);
        evt[k] <= 1;
        @(posedge ref_clk_i);
        evt[k] <= 0;
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Read data is taken only at the completing access edge
    always @(posedge ref_clk_i)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            chk(prdata, q.pop_front());
            chk(pslverr, paddr == 12'h004);    // Only the hole errs
        end
    end

    // Whole run is about 1200 cycles; this only cuts a hang
    initial
    begin
        cyc(20000);
        error_cnt++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(2);
        rst_n_i <= 1;
        void'($urandom(32'hA26B));
        r = $urandom;
        rd(A_PIN, 0);                              // reset value
        rd(A_SRC, 0);                              // reset value
        rd(12'h004, 0);                            // unmapped place
        chk(line, 0);                              // idle level
        wr(A_PIN, r);
        rd(A_PIN, r & 32'(irq_cfg_pkg::PIN_CFG_MASK));
        wr(A_SRC, 32'hFF);
        rd(A_SRC, 32'h59);
        wr(A_PIN, 32'h20);
        // Motion, overflow and raw ready each latched until its status is read
        for (int k = 0; k < 3; k++)
        begin
            ev(k);
            cyc(2);
            chk(line, 1);
            rd(A_ST, stat_bit[k]);
            cyc(2);
            chk(line, 0);
        end
        wr(A_SRC, 0);
        ev(0);
        cyc(2);
        chk(line, 0);
        rd(A_SRC, 0);
        rd(A_ST, 32'h40);
        wr(A_SRC, 32'h59);
        wr(A_PIN, 32'hF0);
        cyc(2);
        chk(line, 1);
        ev(1);
        cyc(2);
        chk(line, 0);
        chk(pin_oe, 1);
        rd(A_SRC, 32'h59);
        cyc(2);
        chk(line, 1);
        rd(A_ST, 0);
        // Frame sync, active low, falling input is the active edge
        wr(A_PIN, 32'h2C);
        // One cycle under the new polarity, so the edge is seen
        cyc(1);
        fs <= 0;
        cyc(3);
        chk(line, 1);
        rd(A_AUX, 32'h80);
        rd(A_AUX, 0);
        rd(A_ST, 32'h08);
        wr(A_PIN, 32'h28);
        fs <= 1;
        cyc(2);
        fs <= 0;
        cyc(3);
        rd(A_ST, 0);
        // Raw ready held back while waiting on the external sensor
        wr(A_MST, 32'h40);
        ms_en <= 1;
        ev(2);
        cyc(2);
        rd(A_ST, 0);
        done <= 1;
        cyc(1);
        done <= 0;
        cyc(2);
        rd(A_ST, 32'h01);
        wr(A_MST, 0);
        wr(A_PIN, 32'h02);
        cyc(2);
        chk(byp, 0);
        ms_en <= 0;
        cyc(2);
        chk(byp, 1);
        hck <= 0;
        cyc(2);
        chk({ck_oe, da_oe}, 2'h3);
        hck <= 1;
        wr(A_PIN, 0);
        cyc(2);
        chk(byp, 0);
        chk({ck_oe, da_oe}, 0);
        // Pulse mode: 1000 cycles active per event
        ev(2);
        cyc(3);
        chk(line, 1);
        cyc(900);
        chk(line, 1);
        cyc(97);
        chk(line, 1);
        cyc(1);
        chk(line, 0);
        rd(A_ST, 32'h01);
        wr(A_EVS, 32'hFF);
        wr(A_MSK, 32'hFF);
        ev(0);
        cyc(2);
        chk(irq, 1);
        wr(A_MSK, 0);
        cyc(1);
        chk(irq, 0);
        wr(A_MSK, 32'hFF);
        wr(A_EVS, 32'hFF);
        cyc(2);
        chk(irq, 0);
        stop_test();
    end
endmodule // tb_interrupt_pin_and_enable_control
`default_nettype wire
